// ---- core/dba_dma_chan.sv ----
`timescale 1ns/1ps
`default_nettype none

module dba_dma_chan
   import dba_pkg::*;
#(
   parameter logic [3:0] CHANNEL = DMA_CHAN_PAIR_ONE
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ownBus,
   dba_dma_if.chan port,
   output logic [3:0] channel
);

   // ---------------------------------------------------------------
   // External DMA request and grant pair
   // ---------------------------------------------------------------
   typedef struct packed {
      logic request;
      logic grant;
   } dba_dma_s;

   dba_dma_s state_q;
   dba_dma_s state_d;

   always_comb begin
      state_d.request = ~port.requestN; // R20
      // A grant is only meaningful while this processor owns the bus.
      state_d.grant = port.chanGrant & ownBus;
      if (rst) begin
         state_d.request = 1'b0;
         state_d.grant = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      state_q <= state_d;
   end

   assign channel = CHANNEL; // R20
   assign port.chanRequest = state_q.request;
   assign port.grantN = ~state_q.grant;
   assign port.grantOe = ownBus;

endmodule

`default_nettype wire

// ---- core/dba_dma_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface dba_dma_if;
   logic requestN;
   logic chanRequest;
   logic chanGrant;
   logic grantN;
   logic grantOe;

   modport chan (
      input requestN,
      input chanGrant,
      output chanRequest,
      output grantN,
      output grantOe
   );

   modport top (
      output requestN,
      output chanGrant,
      input chanRequest,
      input grantN,
      input grantOe
   );
endinterface

`default_nettype wire

// ---- core/dba_pkg.sv ----
// Function
// R1: Owner yields bus, then grants host.
// R2: Host ownership floats address, data, strobes.
// R3: SDRAM controls stay driven under host.
// R4: Host request beats peer requests; a yield due on the host's take edge still hands the bus to the peer.
// R5: Grant held until host request released.
// R6: Only bus owner drives host grant.
// R7: Host asserts chip select to access.
// R8: Ready low while host access waits.
// R9: Ready open-drain unless active-drive bit set.
// R10: Ready driven only with select and request.
// R11: Drive own request line, watch other.
// R12: Number 01 line one, 10 two, 00 single.
// R13: Processor number changes only in reset.
// R14: Core priority preempts background DMA.
// R15: Core priority line is open-drain, shared.
// R16: Ownership handover costs one cycle only.
// R17: Bus lock keeps ownership across sequences.
// R18: Peer can raise a vector interrupt.
// R19: Boot source from select pins.
// R20: Request pair one channel 9, two 8.
// R21: At most two processors plus one host.
// R22: Pins sampled on clock, decisions on edges.
package dba_pkg;

   localparam int SYNC_STAGES = 2;
   localparam int PROC_LINES = 2;

   localparam logic [1:0] PROC_SINGLE = 2'h0;
   localparam logic [1:0] PROC_ONE = 2'h1;
   localparam logic [1:0] PROC_TWO = 2'h2;

   localparam logic [3:0] DMA_CHAN_PAIR_ONE = 4'h9;
   localparam logic [3:0] DMA_CHAN_PAIR_TWO = 4'h8;

   localparam logic [7:0] VECTOR_RESET = 8'h00;

   typedef enum logic [1:0] {
      BOOT_EPROM8,
      BOOT_HOST,
      BOOT_EXT_MEMORY
   } dba_boot_e;

   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_RELEASE,
      HOST_GRANTED
   } dba_host_e;

endpackage

// ---- core/dba_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module dba_sync
   import dba_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);

   // ---------------------------------------------------------------
   // Two-stage synchroniser
   // ---------------------------------------------------------------
   // The first stage feeds only the second stage. There is no reset
   // here: the straps are read through this path while reset holds.
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } dba_sync_s;

   dba_sync_s state_q;
   dba_sync_s state_d;

   always_comb begin
      state_d.meta = async;
      state_d.stable = state_q.meta;
   end

   always_ff @(posedge core_clk) begin
      state_q <= state_d;
   end

   assign synced = state_q.stable;

endmodule

`default_nettype wire

// ---- core/dba_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module dba_top
   import dba_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic host_bus_request_n,
   output logic hostBusGrantN,
   output logic hostBusGrantOe,
   input wire logic chipSelectN,
   output logic hostAckReady,
   output logic hostAckReadyOe,
   input wire logic ackActiveDriveBit,
   input wire logic hostAccessPending,
   input wire logic hostAccessDone,
   input wire logic [1:0] peerBusRequestNIn,
   output logic [1:0] peerBusRequestNOut,
   output logic [1:0] peerBusRequestNOe,
   input wire logic [1:0] processorNumber,
   input wire logic corePriorityNIn,
   output logic corePriorityNOut,
   output logic corePriorityNOe,
   input wire logic coreBusRequest,
   input wire logic dmaBusRequest,
   input wire logic busLock,
   output logic dmaPreempted,
   output logic extBusOe,
   output logic sdramCtlOe,
   output logic ownBus,
   output logic hostOwnsBus,
   input wire logic peerVectorWrite,
   input wire logic [7:0] peerVectorData,
   input wire logic vectorAck,
   output logic vectorIrq,
   output logic [7:0] vectorValue,
   input wire logic eprom_boot_select,
   input wire logic boot_memory_select,
   output dba_boot_e bootMode,
   input wire logic extDmaRequestOneN,
   input wire logic extDmaRequestTwoN,
   output logic extDmaGrantOneN,
   output logic extDmaGrantTwoN,
   output logic extDmaGrantOe,
   output logic dmaChan9Request,
   output logic dmaChan8Request,
   input wire logic dmaChan9Grant,
   input wire logic dmaChan8Grant
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int PIN_W = 11;

   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] pinSync;
   logic hbrSync;
   logic csSync;
   logic [1:0] peerReqSync;
   logic cpaSync;
   logic [1:0] numSync;
   logic bselSync;
   logic bmsSync;
   logic dmaReqOneSync;
   logic dmaReqTwoSync;

   assign pinRaw = {host_bus_request_n, chipSelectN, peerBusRequestNIn,
                    corePriorityNIn, processorNumber, eprom_boot_select,
                    boot_memory_select, extDmaRequestOneN,
                    extDmaRequestTwoN};

   // Straps ride the same synchroniser as the handshake pins; reset is
   // held long enough for them to settle before they are taken.
   dba_sync #(
      .WIDTH(PIN_W)
   ) u_pinSync (
      .core_clk(core_clk),
      .async(pinRaw),
      .synced(pinSync)
   ); // R22

   assign {hbrSync, csSync, peerReqSync, cpaSync, numSync, bselSync,
           bmsSync, dmaReqOneSync, dmaReqTwoSync} = pinSync;

   // ---------------------------------------------------------------
   // Boot strap decode
   // ---------------------------------------------------------------
   // Decoded every cycle but taken only while reset holds, so a later
   // change on the pins cannot move the boot source.
   dba_boot_e bootStrap;

   always_comb begin
      if (bselSync) begin
         bootStrap = BOOT_EPROM8; // R19
      end else if (bmsSync) begin
         bootStrap = BOOT_HOST; // R19
      end else begin
         bootStrap = BOOT_EXT_MEMORY; // R19
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] procNum;
      logic ownBus;
      logic peerHeld;
      dba_host_e host;
      logic vectorIrq;
      logic [7:0] vector;
      dba_boot_e boot;
      logic readyLevel;
   } dba_top_s;

   dba_top_s state_q;
   dba_top_s state_d;

   logic multiProc;
   logic myLine;
   logic peerReq;
   logic cpaSeen;
   logic hostReq;
   logic wantBus;
   logic hostHolds;
   logic yield;
   logic acquire;

   // The number is held from reset, so a glitch on the pins later on
   // cannot move this processor onto the other request line.
   assign multiProc = (state_q.procNum == PROC_ONE) |
                      (state_q.procNum == PROC_TWO); // R12
   assign myLine = (state_q.procNum == PROC_TWO); // R12
   assign peerReq = multiProc & ~peerReqSync[~myLine]; // R11
   assign cpaSeen = multiProc & ~cpaSync;
   assign hostReq = ~hbrSync;
   assign hostHolds = (state_q.host != HOST_IDLE);

   // Background DMA gives way while a slave core claims priority.
   assign dmaPreempted = state_q.ownBus & cpaSeen & ~coreBusRequest; // R14
   assign wantBus = coreBusRequest | (dmaBusRequest & ~dmaPreempted) |
                    (busLock & state_q.ownBus); // R17

   // Yielding and taking happen on one edge each; the peer sees the
   // request line drop and may take over on the next edge.
   assign yield = state_q.ownBus & multiProc & peerReq & ~busLock &
                  ~hostHolds & (~wantBus | dmaPreempted); // R16 R17 R4
   assign acquire = ~state_q.ownBus & multiProc & wantBus & ~hostHolds &
                    (~peerReq | (~state_q.peerHeld & ~myLine)); // R16 R21

   // ---------------------------------------------------------------
   // Decision terms
   // ---------------------------------------------------------------
   logic hostTake;
   logic peerHeldNext;

   // A locked owner finishes its indivisible sequence before the host
   // is let in; a processor that does not own the bus leaves the host
   // to its peer.
   assign hostTake = hostReq & state_q.ownBus & ~busLock; // R1 R4 R17

   // Once the bus has been handed over, the peer owns it until its
   // request line rises. Without this the core could take the bus
   // straight back on the edge after yielding.
   assign peerHeldNext = peerReq & (~state_q.ownBus | yield); // R16

   always_comb begin
      state_d = state_q;
      state_d.peerHeld = peerHeldNext;
      if (!multiProc) begin
         state_d.ownBus = 1'b1;
      end else if (yield) begin
         state_d.ownBus = 1'b0;
      end else if (acquire) begin
         state_d.ownBus = 1'b1;
      end

      unique case (state_q.host)
         HOST_IDLE: begin
            // Host wins over a peer request unless a yield falls on the same edge; a lock defers it.
            if (hostTake) begin
               state_d.host = HOST_RELEASE; // R1 R4
            end
         end
         HOST_RELEASE: begin
            // The bus is already floated here; grant follows next edge.
            state_d.host = hostReq ? HOST_GRANTED : HOST_IDLE; // R1
         end
         HOST_GRANTED: begin
            if (!hostReq) begin
               state_d.host = HOST_IDLE; // R5
            end
         end
      endcase

      // Ready stays low while the access waits; completion wins.
      state_d.readyLevel = ~hostAccessPending | hostAccessDone; // R8

      if (peerVectorWrite) begin
         state_d.vectorIrq = 1'b1; // R18
         state_d.vector = peerVectorData;
      end else if (vectorAck) begin
         state_d.vectorIrq = 1'b0;
      end

      if (rst) begin
         // Straps are caught while reset holds and frozen after it.
         state_d.procNum = numSync; // R13
         state_d.ownBus = 1'b0;
         state_d.peerHeld = 1'b0;
         state_d.host = HOST_IDLE;
         state_d.vectorIrq = 1'b0;
         state_d.vector = VECTOR_RESET;
         state_d.readyLevel = 1'b1;
         state_d.boot = bootStrap; // R19
      end
   end

   always_ff @(posedge core_clk) begin
      state_q <= state_d;
   end

   // ---------------------------------------------------------------
   // Host side pins
   // ---------------------------------------------------------------
   logic readyWindow;

   assign hostOwnsBus = hostHolds;
   assign hostBusGrantN = ~(state_q.host == HOST_GRANTED); // R1 R5
   assign hostBusGrantOe = state_q.ownBus & ~rst; // R6
   assign extBusOe = state_q.ownBus & ~hostHolds & ~rst; // R2
   // Memory controls stay driven under host ownership, so the memory
   // sees them float only while reset holds.
   assign sdramCtlOe = ~rst; // R3

   // The host's select and bus request together qualify any answer on ready.
   assign readyWindow = ~csSync & hostReq & ~rst; // R7 R10
   assign hostAckReady = ackActiveDriveBit ? state_q.readyLevel : 1'b0; // R9
   assign hostAckReadyOe = readyWindow &
                           (ackActiveDriveBit | ~state_q.readyLevel); // R9 R10

   // ---------------------------------------------------------------
   // Peer arbitration pins
   // ---------------------------------------------------------------
   logic reqActive;

   assign reqActive = multiProc & (state_d.ownBus | wantBus) & ~rst;
   assign peerBusRequestNOut = 2'h3;
   assign peerBusRequestNOe = {reqActive & myLine, reqActive & ~myLine}; // R11

   // Wired line shared by both processors: pulled low, never driven high.
   assign corePriorityNOut = 1'b0; // R15
   assign corePriorityNOe = multiProc & ~state_q.ownBus & coreBusRequest &
                            ~rst; // R14 R15

   assign ownBus = state_q.ownBus;
   assign vectorIrq = state_q.vectorIrq;
   assign vectorValue = state_q.vector;
   assign bootMode = state_q.boot;

   // ---------------------------------------------------------------
   // External DMA pairs
   // ---------------------------------------------------------------
   dba_dma_if dmaOne ();
   dba_dma_if dmaTwo ();

   assign dmaOne.requestN = dmaReqOneSync;
   assign dmaOne.chanGrant = dmaChan9Grant;
   assign dmaTwo.requestN = dmaReqTwoSync;
   assign dmaTwo.chanGrant = dmaChan8Grant;

   dba_dma_chan #(
      .CHANNEL(DMA_CHAN_PAIR_ONE)
   ) u_dmaOne (
      .core_clk(core_clk),
      .rst(rst),
      .ownBus(extBusOe),
      .port(dmaOne.chan),
      .channel()
   ); // R20

   dba_dma_chan #(
      .CHANNEL(DMA_CHAN_PAIR_TWO)
   ) u_dmaTwo (
      .core_clk(core_clk),
      .rst(rst),
      .ownBus(extBusOe),
      .port(dmaTwo.chan),
      .channel()
   ); // R20

   assign dmaChan9Request = dmaOne.chanRequest;
   assign dmaChan8Request = dmaTwo.chanRequest;
   assign extDmaGrantOneN = dmaOne.grantN;
   assign extDmaGrantTwoN = dmaTwo.grantN;
   // Both pairs share one enable: a grant is only driven while this
   // processor owns the external bus.
   assign extDmaGrantOe = dmaOne.grantOe;

endmodule

`default_nettype wire

// ---- verif/dba_host_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none

// One host only, which is all the shared bus allows.
module dba_host_bfm (
   input wire logic core_clk,
   input wire logic start,
   input wire logic [3:0] holdCycles,
   input wire logic hostBusGrantN,
   output logic host_bus_request_n,
   output logic chipSelectN,
   output logic timedOut
);
   int n;

   initial begin
      host_bus_request_n = 1'b1;
      chipSelectN = 1'b1;
      timedOut = 1'b0;
   end

   always @(posedge start) begin
      host_bus_request_n = 1'b0;
      chipSelectN = 1'b0;
      n = 0;
      do begin
         @(posedge core_clk) #1;
         n++;
      end while (hostBusGrantN !== 1'b0 && n < 20);
      timedOut = (n == 20);
      repeat (holdCycles) @(posedge core_clk);
      #1;
      host_bus_request_n = 1'b1;
      chipSelectN = 1'b1;
   end
endmodule

`default_nettype wire

// ---- verif/dba_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module dba_top_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic host_bus_request_n,
   input wire logic hostBusGrantN,
   input wire logic chipSelectN,
   input wire logic hostAckReady,
   input wire logic hostAckReadyOe,
   input wire logic ackActiveDriveBit,
   input wire logic hostAccessPending,
   input wire logic hostAccessDone,
   input wire logic [1:0] peerBusRequestNOe,
   input wire logic [1:0] processorNumber,
   input wire logic corePriorityNOut,
   input wire logic busLock,
   input wire logic extBusOe,
   input wire logic sdramCtlOe,
   input wire logic ownBus,
   input wire logic hostOwnsBus
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Four samples cover the two synchroniser stages, the decision edge and the release edge.
   sequence s_hostTake;
      (!host_bus_request_n && ownBus && !busLock) [*4];
   endsequence
   sequence s_hostHeld;
      !hostBusGrantN && !host_bus_request_n;
   endsequence

   property p_grant;
      s_hostTake |=> !hostBusGrantN;
   endproperty
   property p_yieldFirst;
      $fell(hostBusGrantN) |-> !extBusOe && $past(!extBusOe);
   endproperty
   property p_float;
      hostOwnsBus |-> !extBusOe;
   endproperty
   property p_sdram;
      hostOwnsBus |-> sdramCtlOe;
   endproperty
   property p_hold;
      s_hostHeld |=> !hostBusGrantN;
   endproperty
   property p_window;
      hostAckReadyOe |-> $past(!chipSelectN, 2) && $past(!host_bus_request_n, 2);
   endproperty
   property p_level;
      hostAccessPending && !hostAccessDone && ackActiveDriveBit |=> !hostAckReady;
   endproperty
   property p_openDrain;
      !ackActiveDriveBit |-> !hostAckReady;
   endproperty
   property p_ownLine;
      (peerBusRequestNOe & ~processorNumber) == 2'h0;
   endproperty
   property p_cpa;
      !corePriorityNOut;
   endproperty

   a_grant: assert property (p_grant) else $error("grant late");
   a_yieldFirst: assert property (p_yieldFirst) else $error("no yield");
   a_float: assert property (p_float) else $error("bus driven");
   a_sdram: assert property (p_sdram) else $error("sdram off");
   a_hold: assert property (p_hold) else $error("grant dropped");
   a_window: assert property (p_window) else $error("ready out");
   a_level: assert property (p_level) else $error("no wait");
   a_openDrain: assert property (p_openDrain) else $error("ready hi");
   a_ownLine: assert property (p_ownLine) else $error("wrong line");
   a_cpa: assert property (p_cpa) else $error("cpa driven");
endmodule

bind dba_top dba_top_sva u_sva (.*);

`default_nettype wire

// ---- verif/dba_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module dba_top_tb;
   logic core_clk = 1'b0, rst = 1'b1, start = 1'b0, timedOut;
   logic host_bus_request_n, chipSelectN, hostBusGrantN, hostBusGrantOe;
   logic hostAckReady, hostAckReadyOe, ackActiveDriveBit = 1'b0;
   logic hostAccessPending = 1'b0, hostAccessDone = 1'b0;
   logic [1:0] peerBusRequestNIn, peerBusRequestNOut, peerBusRequestNOe;
   logic [1:0] processorNumber = 2'h0, peerLine = 2'h3;
   logic corePriorityNIn, corePriorityNOut, corePriorityNOe;
   logic coreBusRequest = 1'b0, dmaBusRequest = 1'b0, busLock = 1'b0;
   logic dmaPreempted, extBusOe, sdramCtlOe, ownBus, hostOwnsBus;
   logic peerVectorWrite = 1'b0, vectorAck = 1'b0, vectorIrq;
   logic [7:0] peerVectorData = 8'h00, vectorValue;
   logic eprom_boot_select = 1'b0, boot_memory_select = 1'b0;
   dba_pkg::dba_boot_e bootMode;
   logic extDmaRequestOneN = 1'b1, extDmaRequestTwoN = 1'b1;
   logic extDmaGrantOneN, extDmaGrantTwoN, extDmaGrantOe;
   logic dmaChan9Request, dmaChan8Request;
   logic dmaChan9Grant = 1'b0, dmaChan8Grant = 1'b0;
   logic [7:0] expQ[$], obsQ[$];
   int num_errors = 0, checked = 0, i, k;
   event got;

   // Released request lines and the priority line float up to their pull-ups.
   assign peerBusRequestNIn = ~peerBusRequestNOe & peerLine;
   assign corePriorityNIn = ~corePriorityNOe;

   always #10 core_clk = ~core_clk;

   dba_top uut (.*);
   dba_host_bfm host (.core_clk(core_clk), .start(start),
      .holdCycles(4'h6), .hostBusGrantN(hostBusGrantN),
      .host_bus_request_n(host_bus_request_n),
      .chipSelectN(chipSelectN), .timedOut(timedOut));

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic note(input logic [7:0] seen, input logic [7:0] want);
      obsQ.push_back(seen);
      expQ.push_back(want);
      ->got;
   endtask

   always @(got) begin
      while (expQ.size() > 0) check(obsQ.pop_front(), expQ.pop_front());
   end

   task automatic step;
      @(posedge core_clk) #1;
   endtask

   task automatic waitFor(ref logic sig, input logic lvl);
      for (i = 0; i < 50 && sig !== lvl; i++) step();
      if (i == 50) begin
         num_errors++;
         conclude();
      end
   endtask

   // Three edges let the synchronisers fill before the straps are taken.
   task automatic doReset;
      rst = 1'b1;
      repeat (3) step();
      rst = 1'b0;
      repeat (3) step();
   endtask

   initial begin
      void'($urandom(32'h13231E98));
      for (k = 0; k < 3; k++) begin
         eprom_boot_select = (k == 0);
         boot_memory_select = (k == 1);
         doReset();
         note(8'(bootMode), 8'(k));
      end
      $display("boot test done");
      busLock = 1'b1;
      ackActiveDriveBit = 1'b1;
      start = 1'b1;
      repeat (8) step();
      note(8'(hostBusGrantN), 8'h01);
      start = 1'b0;
      busLock = 1'b0;
      waitFor(hostBusGrantN, 1'b0);
      hostAccessPending = 1'b1;
      step();
      note(8'({extBusOe, sdramCtlOe, hostOwnsBus}), 8'h03);
      note(8'({hostAckReady, hostAckReadyOe}), 8'h01);
      hostAccessPending = 1'b0;
      step();
      note(8'(hostBusGrantN), 8'h00);
      waitFor(hostBusGrantN, 1'b1);
      note(8'({hostAckReadyOe, timedOut}), 8'h00);
      $display("host test done");
      peerVectorData = 8'($urandom);
      peerVectorWrite = 1'b1;
      step();
      peerVectorWrite = 1'b0;
      note(vectorValue, peerVectorData);
      note(8'(vectorIrq), 8'h01);
      vectorAck = 1'b1;
      step();
      vectorAck = 1'b0;
      note(8'(vectorIrq), 8'h00);
      $display("vector test done");
      waitFor(extBusOe, 1'b1);
      dmaChan9Grant = 1'b1;
      extDmaRequestOneN = 1'b0;
      step();
      note(8'({extDmaGrantOneN, extDmaGrantTwoN}), 8'h01);
      waitFor(dmaChan9Request, 1'b1);
      note(8'(dmaChan8Request), 8'h00);
      dmaChan9Grant = 1'b0;
      dmaChan8Grant = 1'b1;
      step();
      note(8'({extDmaGrantOneN, extDmaGrantTwoN}), 8'h02);
      $display("dma test done");
      rst = 1'b1;
      processorNumber = 2'h1;
      doReset();
      coreBusRequest = 1'b1;
      waitFor(ownBus, 1'b1);
      note(8'(peerBusRequestNOe[1]), 8'h00);
      coreBusRequest = 1'b0;
      peerLine[1] = 1'b0;
      repeat (3) step();
      note(8'(ownBus), 8'h00);
      coreBusRequest = 1'b1;
      repeat (2) step();
      note(8'(corePriorityNOe), 8'h01);
      $display("peer test done");
      #1;
      conclude();
   end
endmodule

`default_nettype wire
